// *** pkg/dccl_params.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers on a plain strobe port
// Notes:   definitions only
`ifndef DCCL_PARAMS_SVH
`define DCCL_PARAMS_SVH

`define DCCL_ADDR_W          3
`define DCCL_OFF_CTRL0       3'h0
`define DCCL_OFF_CTRL1       3'h1
`define DCCL_OFF_SHARED      3'h2
`define DCCL_OFF_FLAGS       3'h3
`define DCCL_OFF_ENABLES     3'h4

`define DCCL_CTRL_ON         7
`define DCCL_CTRL_OUT        6
`define DCCL_CTRL_OE         5
`define DCCL_CTRL_POL        4
`define DCCL_CTRL_SP         3
`define DCCL_CTRL_REF        2
`define DCCL_CTRL_CH_HI      1
`define DCCL_CTRL_CH_LO      0
`define DCCL_CTRL_RESET      8'h08
`define DCCL_CTRL_WMASK      8'hBF

`define DCCL_SH_MOUT1        7
`define DCCL_SH_MOUT2        6
`define DCCL_SH_RESET        8'h00
`define DCCL_SH_WMASK        8'h3F

`define DCCL_FLG_RESET       8'h00
`define DCCL_EN_RESET        8'h00

`define DCCL_PHASES          4
`define DCCL_PH_W            2
`define DCCL_PH_ONE          2'h0
`define DCCL_PH_TWO          2'h1
`define DCCL_PH_THREE        2'h2
`define DCCL_PH_FOUR         2'h3

`endif

// *** pkg/dccl_pkg.sv ***
// Purpose: shared types of the comparator change logic
// Assumes: nothing
// Notes:   constants live in dccl_params.svh
package dccl_pkg;

   typedef enum logic [1:0] {
      DCCL_PH1 = 2'b00,
      DCCL_PH2 = 2'b01,
      DCCL_PH3 = 2'b10,
      DCCL_PH4 = 2'b11
   } dccl_phase_e;

   typedef struct packed {
      logic       enable;
      logic       out_bit;
      logic       pin_en;
      logic       invert;
      logic       speed;
      logic       ref_sel;
      logic [1:0] chan;
   } dccl_ctrl_s;

   typedef struct packed {
      logic       enable;
      logic       speed;
      logic       ref_sel;
      logic [1:0] chan;
   } dccl_analog_s;

endpackage : dccl_pkg

// *** verilog/dccl_channel.sv ***
// Purpose: one comparator channel: control, output stage, mismatch latches
// Assumes: phase strobes and access pulses from the top, same clock
// Notes:   raw comparison arrives already synchronised
`include "dccl_params.svh"
module dccl_channel (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire logic              raw_in,
   input  wire logic              access_in,
   input  wire logic              wr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              ph_one_in,
   input  wire logic              ph_three_in,
   output dccl_pkg::dccl_ctrl_s   ctrl_out,
   output logic                   out_bit_out,
   output logic                   mismatch_out
);
   dccl_pkg::dccl_ctrl_s ctrl;
   logic                 out_reg;
   logic                 latch_one;
   logic                 latch_three;
   logic                 access_pend;
   logic                 wr_pend;
   logic [7:0]           wr_data;
   logic                 gated;
   logic                 next_out;

   // disabled comparator feeds zero into the inversion stage
   assign gated    = ctrl.enable & raw_in;
   assign next_out = gated ^ ctrl.invert;

   // output registered once per instruction cycle, at phase one
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         out_reg <= 1'b0;
      end else if (ph_one_in) begin
         out_reg <= next_out;
      end
   end

   // access pulses are held until phase three
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         access_pend <= 1'b0;
         wr_pend     <= 1'b0;
         wr_data     <= 8'h00;
      end else if (ph_three_in) begin
         // an access is consumed at this edge; never replay it a cycle later
         access_pend <= 1'b0;
         wr_pend     <= 1'b0;
         wr_data     <= wdata_in;
      end else if (access_in) begin
         access_pend <= 1'b1;
         wr_pend     <= wr_in;
         wr_data     <= wdata_in;
      end
   end

   // latch one follows the output at phase three of a register access,
   // the read half of every write lands here too
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         latch_three <= 1'b0;
      end else if (ph_three_in && (access_pend || access_in)) begin
         latch_three <= out_reg;
      end
   end

   // latch two follows the output at phase one of every cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         latch_one <= 1'b0;
      end else if (ph_one_in) begin
         latch_one <= out_reg;
      end
   end

   // new settings apply at phase three, on the same edge where the read latches the old output
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl <= dccl_pkg::dccl_ctrl_s'(`DCCL_CTRL_RESET);
      end else if (ph_three_in && (wr_pend || (access_in && wr_in))) begin
         ctrl <= dccl_pkg::dccl_ctrl_s'(
            (access_in && wr_in ? wdata_in : wr_data) & `DCCL_CTRL_WMASK);
      end
   end

   always_comb begin
      ctrl_out         = ctrl;
      ctrl_out.out_bit = out_reg;
   end
   assign out_bit_out  = out_reg;
   assign mismatch_out = latch_one ^ latch_three;

endmodule : dccl_channel

// *** verilog/dccl_top.sv ***
// Purpose: two-comparator control, change detection and interrupt request
// Assumes: analog results arrive as asynchronous levels; the bus strobes
//          and interrupt enables are on clk_in
// Notes:   analog routing leaves as control levels to the front end
`include "dccl_params.svh"

// Notes on behaviour
// - raw result high when noninverting exceeds inverting
// - output_invert inverts the reported output
// - comparator_enable powers the comparator on
// - channel_select routes one of four pins
// - noninv_ref_select picks reference or pin
// - pin drive needs pin enable, direction, enable
// - pin enable overrides port data latch
// - internal output registered each instruction cycle
// - speed_power_select resets to normal speed
// - output readable in own and shared register
// - first latch captures at phase three access
// - second latch captures every phase one
// - mismatch is xor of both latches
// - write also clears the mismatch
// - flag set on mismatch rising edge
// - software clears flag, writing one sets it
// - interrupt needs all three enables set
// - disabled comparator feeds zero to inverter
// - access latches first, write applies last
// - output change during read may miss flag
// - enabled comparator runs and wakes in sleep
// - reset returns control registers to defaults
// - reference select one routes internal reference
// - shared register read leaves mismatch untouched
module dccl_top #(
   parameter int CHANNELS = 2
) (
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   input  wire logic [`DCCL_ADDR_W-1:0]   addr_in,
   input  wire logic [7:0]                wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [7:0]                rdata_out,
   input  wire logic [CHANNELS-1:0]       raw_result_in,
   input  wire logic [CHANNELS-1:0]       pin_direction_bit_in,
   input  wire logic [CHANNELS-1:0]       port_data_in,
   input  wire logic                      sleep_in,
   input  wire logic                      peripheral_int_enable_in,
   input  wire logic                      global_int_enable_in,
   output dccl_pkg::dccl_analog_s [CHANNELS-1:0] analog_out,
   output logic      [CHANNELS-1:0]       pin_out,
   output logic      [CHANNELS-1:0]       pin_oe_out,
   output logic      [CHANNELS-1:0]       internal_out,
   output logic      [5:0]                shared_cfg_out,
   output logic                           irq_out,
   output logic                           wake_out
);
   // ------------------------------------------------------------
   // phase sequencer
   // ------------------------------------------------------------
   dccl_pkg::dccl_phase_e      phase;
   dccl_pkg::dccl_phase_e      next_phase;
   logic                       ph_one;
   logic                       ph_three;

   // phase one is held during sleep so the second latch keeps tracking
   always_comb begin
      next_phase = phase;
      unique case (phase)
         dccl_pkg::DCCL_PH1: next_phase = sleep_in ? dccl_pkg::DCCL_PH1
                                                   : dccl_pkg::DCCL_PH2;
         dccl_pkg::DCCL_PH2: next_phase = dccl_pkg::DCCL_PH3;
         dccl_pkg::DCCL_PH3: next_phase = dccl_pkg::DCCL_PH4;
         dccl_pkg::DCCL_PH4: next_phase = dccl_pkg::DCCL_PH1;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         phase <= dccl_pkg::DCCL_PH1;
      end else begin
         phase <= next_phase;
      end
   end

   assign ph_one   = (phase == dccl_pkg::DCCL_PH1);
   assign ph_three = (phase == dccl_pkg::DCCL_PH3) && !sleep_in;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [CHANNELS-1:0]        raw_meta;
   logic [CHANNELS-1:0]        raw_sync;
   logic [CHANNELS-1:0]        dir_meta;
   logic [CHANNELS-1:0]        dir_sync;
   logic [CHANNELS-1:0]        port_meta;
   logic [CHANNELS-1:0]        port_sync;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         raw_meta  <= '0;
         raw_sync  <= '0;
         dir_meta  <= '1;
         dir_sync  <= '1;
         port_meta <= '0;
         port_sync <= '0;
      end else begin
         raw_meta  <= raw_result_in;
         raw_sync  <= raw_meta;
         dir_meta  <= pin_direction_bit_in;
         dir_sync  <= dir_meta;
         port_meta <= port_data_in;
         port_sync <= port_meta;
      end
   end

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   dccl_pkg::dccl_ctrl_s [CHANNELS-1:0] ctrl;
   logic [CHANNELS-1:0]        out_bit;
   logic [CHANNELS-1:0]        mismatch;
   logic [CHANNELS-1:0]        ctrl_access;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : g_chan
         // only the own control register touches the mismatch latch
         assign ctrl_access[g] = (wr_in || rd_in) &&
            (addr_in == (`DCCL_OFF_CTRL0 + `DCCL_ADDR_W'(g)));
         dccl_channel u_chan (
            .clk_in       (clk_in),
            .rst_in       (rst_in),
            .raw_in       (raw_sync[g]),
            .access_in    (ctrl_access[g]),
            .wr_in        (wr_in),
            .wdata_in     (wdata_in),
            .ph_one_in    (ph_one),
            .ph_three_in  (ph_three),
            .ctrl_out     (ctrl[g]),
            .out_bit_out  (out_bit[g]),
            .mismatch_out (mismatch[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // shared control and interrupt registers
   // ------------------------------------------------------------
   logic [5:0]                 shared_cfg;
   logic [CHANNELS-1:0]        flag;
   logic [CHANNELS-1:0]        int_en;
   logic [CHANNELS-1:0]        mismatch_d;
   logic [CHANNELS-1:0]        rise;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shared_cfg <= 6'(`DCCL_SH_RESET);
      end else if (wr_in && addr_in == `DCCL_OFF_SHARED) begin
         shared_cfg <= wdata_in[5:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         int_en <= '0;
      end else if (wr_in && addr_in == `DCCL_OFF_ENABLES) begin
         int_en <= wdata_in[CHANNELS-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mismatch_d <= '0;
      end else begin
         mismatch_d <= mismatch;
      end
   end

   // rising edge sets the flag whatever the pin enable; set beats clear
   assign rise = mismatch & ~mismatch_d;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag <= '0;
      end else if (wr_in && addr_in == `DCCL_OFF_FLAGS) begin
         flag <= wdata_in[CHANNELS-1:0] | rise;
      end else begin
         flag <= flag | rise;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   logic [7:0]                 next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      unique case (addr_in)
         `DCCL_OFF_CTRL0:   next_rdata = ctrl[0];
         `DCCL_OFF_CTRL1:   next_rdata = ctrl[1];
         `DCCL_OFF_SHARED:  next_rdata = {out_bit[0], out_bit[1],
                                          shared_cfg};
         `DCCL_OFF_FLAGS:   next_rdata = {{(8-CHANNELS){1'b0}}, flag};
         `DCCL_OFF_ENABLES: next_rdata = {{(8-CHANNELS){1'b0}}, int_en};
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= rd_in ? next_rdata : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   integer i;
   localparam dccl_pkg::dccl_ctrl_s CTRL_RST = dccl_pkg::dccl_ctrl_s'(`DCCL_CTRL_RESET);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_out      <= '0;
         pin_oe_out   <= '0;
         internal_out <= '0;
         // front end sees the reset settings, speed bit included
         for (i = 0; i < CHANNELS; i = i + 1) begin
            analog_out[i].enable  <= CTRL_RST.enable;
            analog_out[i].speed   <= CTRL_RST.speed;
            analog_out[i].ref_sel <= CTRL_RST.ref_sel;
            analog_out[i].chan    <= CTRL_RST.chan;
         end
      end else begin
         for (i = 0; i < CHANNELS; i = i + 1) begin
            // pin override ignores enable; driven level needs all three
            pin_oe_out[i]   <= ctrl[i].pin_en & ~dir_sync[i];
            pin_out[i]      <= ctrl[i].pin_en ?
               (out_bit[i] & ctrl[i].enable) : port_sync[i];
            internal_out[i] <= out_bit[i];
            analog_out[i].enable  <= ctrl[i].enable;
            analog_out[i].speed   <= ctrl[i].speed;
            analog_out[i].ref_sel <= ctrl[i].ref_sel;
            analog_out[i].chan    <= ctrl[i].chan;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shared_cfg_out <= 6'(`DCCL_SH_RESET);
         irq_out        <= 1'b0;
         wake_out       <= 1'b0;
      end else begin
         shared_cfg_out <= shared_cfg;
         // a change within the read cycle may be missed by software
         wake_out <= |(flag & int_en) & peripheral_int_enable_in;
         irq_out  <= |(flag & int_en) & peripheral_int_enable_in
                     & global_int_enable_in;
      end
   end

endmodule : dccl_top

// *** tb/dccl_top_chk.sv ***
// Purpose: port-level checks of the comparator change logic
// Assumes: bound into dccl_top, one clock
// Notes:   latch and phase state are not visible here
`include "dccl_params.svh"
module dccl_top_chk #(
   parameter int CHANNELS = 2
) (
   input wire logic                                 clk_in,
   input wire logic                                 rst_in,
   input wire logic [`DCCL_ADDR_W-1:0]              addr_in,
   input wire logic [7:0]                           wdata_in,
   input wire logic                                 wr_in,
   input wire logic                                 rd_in,
   input wire logic [7:0]                           rdata_out,
   input wire dccl_pkg::dccl_analog_s [CHANNELS-1:0] analog_out,
   input wire logic [5:0]                           shared_cfg_out,
   input wire logic                                 irq_out,
   input wire logic                                 wake_out,
   input wire logic                                 peripheral_int_enable_in,
   input wire logic                                 global_int_enable_in
);
   logic       [3:0] since_wr;
   wire  logic [5:0] wlow = wdata_in[5:0];

   default clocking dc @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // cycles since the last control register write
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         since_wr <= 4'hf;
      end else if (wr_in && addr_in < 3'h2) begin
         since_wr <= 4'h0;
      end else if (since_wr != 4'hf) begin
         since_wr <= since_wr + 4'h1;
      end
   end

   // ----
   // checks
   // ----
   rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside a read reply");
   rd_shared_a: assert property ($past(rd_in && addr_in == 3'h2) |-> rdata_out[5:0] == shared_cfg_out)
      else $error("shared read data differs from shared bits");
   sh_write_a: assert property (wr_in && addr_in == 3'h2 |-> ##2 shared_cfg_out == $past(wlow, 2))
      else $error("shared write not applied");
   sh_hold_a: assert property ($changed(shared_cfg_out) |-> $past(wr_in && addr_in == 3'h2, 2))
      else $error("shared bits changed without a write");
   irq_gate_a: assert property (irq_out |-> $past(peripheral_int_enable_in) && $past(global_int_enable_in))
      else $error("interrupt without both enables");
   wake_gate_a: assert property (wake_out |-> $past(peripheral_int_enable_in))
      else $error("wake without peripheral enable");
   rst_state_a: assert property ($fell(rst_in) |-> analog_out == {CHANNELS{5'h08}} && !irq_out && !wake_out)
      else $error("outputs not at reset values");
   cfg_cause_a: assert property ($changed(analog_out) |-> since_wr <= 4'h6)
      else $error("analog config changed without a control write");
endmodule : dccl_top_chk

bind dccl_top dccl_top_chk #(.CHANNELS(CHANNELS)) chk_u (
   .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .analog_out(analog_out),
   .shared_cfg_out(shared_cfg_out), .irq_out(irq_out), .wake_out(wake_out),
   .peripheral_int_enable_in(peripheral_int_enable_in),
   .global_int_enable_in(global_int_enable_in)
);

// *** tb/test_dual_comparator_change_logic.sv ***
// Purpose: self-checking bench of the comparator change logic
// Assumes: strobe bus with read data one cycle later
// Notes:   waits of 20 cycles cover sync, phase and latch delays
module test_dual_comparator_change_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_in   = 1'b0;
   logic       rst_in   = 1'b1;
   logic [2:0] addr_in  = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in    = 1'b0;
   logic       rd_in    = 1'b0;
   logic [1:0] raw      = 2'h0;
   logic [1:0] dir      = 2'h0;
   logic [1:0] pdat     = 2'h0;
   logic       sleep    = 1'b0;
   logic       peie     = 1'b0;
   logic       gie      = 1'b0;
   logic [7:0] rdata_out;
   logic [1:0] pin_out;
   logic [1:0] pin_oe_out;
   logic [1:0] internal_out;
   logic       irq_out;
   logic       wake_out;
   int         mismatches = 0;
   int         n_tests    = 0;
   int         cyc        = 0;

   always #4 clk_in = ~clk_in;

   dccl_top #(.CHANNELS(2)) dut_u (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .raw_result_in(raw),
      .pin_direction_bit_in(dir), .port_data_in(pdat), .sleep_in(sleep),
      .peripheral_int_enable_in(peie), .global_int_enable_in(gie),
      .analog_out(), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
      .internal_out(internal_out),
      .shared_cfg_out(), .irq_out(irq_out), .wake_out(wake_out)
   );

   // ----
   // tasks
   // ----
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1;
      chk(nm, rdata_out, e);
   endtask : rd

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wt

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         final_report();
      end
   end

   // ----
   // tests
   // ----
   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(3'h0, 8'h08, "ctrl0");
      rd(3'h1, 8'h08, "ctrl1");
      rd(3'h2, 8'h00, "shared");
      rd(3'h3, 8'h00, "flags");
      rd(3'h4, 8'h00, "enables");
      rd(3'h5, 8'h00, "unmapped");
      wr(3'h2, 8'hD5);
      rd(3'h2, 8'h15, "shared rw");
      wr(3'h2, 8'h00);
      $display("test reset done");
      // disabled channel: polarity alone sets the output
      raw <= 2'h3;
      wr(3'h1, 8'h18);
      wt(20);
      rd(3'h1, 8'h58, "ctrl1 off");
      rd(3'h2, 8'h40, "mirror1");
      chk("internal", {6'h00, internal_out}, 8'h02);
      wr(3'h1, 8'h08);
      raw <= 2'h1;
      wr(3'h0, 8'h88);
      wt(20);
      rd(3'h0, 8'hC8, "ctrl0 on");
      wr(3'h0, 8'h98);
      wt(20);
      rd(3'h0, 8'h98, "ctrl0 inv");
      rd(3'h2, 8'h00, "mirror0");
      $display("test output done");
      // pin drive and port override
      wr(3'h0, 8'hA8);
      wt(20);
      chk("pin_oe", {7'h00, pin_oe_out[0]}, 8'h01);
      chk("pin", {7'h00, pin_out[0]}, 8'h01);
      dir <= 2'h1;
      wt(10);
      chk("pin_oe dir", {7'h00, pin_oe_out[0]}, 8'h00);
      dir <= 2'h0;
      raw <= 2'h0;
      pdat <= 2'h1;
      wr(3'h0, 8'h88);
      wt(20);
      chk("port latch", {7'h00, pin_out[0]}, 8'h01);
      wr(3'h0, 8'hA8);
      wt(20);
      chk("pin override", {7'h00, pin_out[0]}, 8'h00);
      $display("test pin done");
      // change detection, flag and interrupt
      rd(3'h0, 8'hA8, "ctrl0 sync");
      wt(20);
      wr(3'h3, 8'h00);
      rd(3'h3, 8'h00, "flags clr");
      wr(3'h4, 8'h01);
      peie <= 1'b1;
      gie  <= 1'b1;
      raw  <= 2'h1;
      wt(20);
      rd(3'h3, 8'h01, "flag set");
      chk("irq", {7'h00, irq_out}, 8'h01);
      gie <= 1'b0;
      wt(4);
      chk("irq gie off", {7'h00, irq_out}, 8'h00);
      rd(3'h0, 8'hE8, "ctrl0 high");
      wr(3'h3, 8'h00);
      wt(4);
      chk("wake idle", {7'h00, wake_out}, 8'h00);
      // the change itself happens while asleep
      sleep <= 1'b1;
      raw   <= 2'h0;
      wt(20);
      chk("wake", {7'h00, wake_out}, 8'h01);
      sleep <= 1'b0;
      wr(3'h3, 8'h00);
      rd(3'h3, 8'h00, "flag cleared");
      rd(3'h2, 8'h00, "mirror read");
      // a mirror read must not resync latch one, so this return stays silent
      raw <= 2'h1;
      wt(20);
      rd(3'h3, 8'h00, "no flag");
      rd(3'h0, 8'hE8, "ctrl0 resync");
      wt(8);
      raw <= 2'h0;
      wt(20);
      rd(3'h3, 8'h01, "flag again");
      wr(3'h3, 8'h02);
      rd(3'h3, 8'h02, "flag by write");
      $display("test change done");
      final_report();
   end
endmodule : test_dual_comparator_change_logic
